// >>> design/pmc_pkg.sv
// Constants, types and helpers shared by the power-mode controller files.
// Assumes a single 125 MHz clock; oscillator cycles arrive as enable ticks.
`default_nettype none

package pmc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the AXI4-Lite slave)
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_WAKE = 8'h08;
  localparam logic [7:0] OFF_CFG = 8'h0c;

  // ==========================================================================
  // Field positions
  localparam int MODE_HIGH_LOW_CLOCK_SELECT_BIT = 0;
  localparam int MODE_IDLE_ON_HALT_ENABLE_BIT = 1;
  localparam int MODE_CKS_LSB = 5;
  localparam int MODE_KEEP_BIT = 8;
  localparam int STAT_PDF_BIT = 0;
  localparam int STAT_TO_BIT = 1;
  localparam int STAT_HTO_BIT = 2;
  localparam int STAT_LTO_BIT = 3;
  localparam int STAT_STATE_LSB = 4;
  localparam int CFG_WDT_ON = 0;
  localparam int CFG_VDET_ON = 1;
  localparam int CFG_LCD_ON = 2;
  localparam int CFG_WDT_SUB = 3;
  localparam int CFG_HI_XTAL = 4;
  localparam int CFG_LO_XTAL = 5;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] MODE_RST = 32'h0000_0003;
  localparam logic [31:0] CFG_RST = 32'h0000_0039;
  localparam logic [7:0] WAKE_RST = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int SUB_HZ = 32_768;
  localparam logic [11:0] SUB_DIV = 12'(CLK_HZ / SUB_HZ);
  localparam logic [10:0] XTAL_CYCLES = 11'h400;
  localparam logic [10:0] HI_RC_CYCLES = 11'h010;
  localparam logic [10:0] LO_RC_CYCLES = 11'h002;

  // ==========================================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_DEEP = 3'b001,
    ST_LIGHT = 3'b010,
    ST_LOW_IDLE = 3'b011,
    ST_FULL_IDLE = 3'b100
  } pmc_state_t;

  typedef enum logic [1:0] {
    SRC_HIGH = 2'b00,
    SRC_DIV = 2'b01,
    SRC_SUB = 2'b10
  } pmc_clksrc_t;

  // Selector 000/001 with the fast bit low means run from the sub clock
  function automatic logic is_slow(input logic hl, input logic [2:0] cks);
    is_slow = !hl && (cks[2:1] == 2'b00);
  endfunction

  // Byte-lane merge of a bus write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

endpackage

`default_nettype wire

// >>> design/pmc_osc_if.sv
// Link between the controller and one oscillator ready counter.
// Assumes both ends share aclk.
`default_nettype none

interface pmc_osc_if;
  logic run;
  logic crystal;
  logic tick;
  logic ready;
  modport ctl (output run, output crystal, output tick, input ready);
  modport osc (input run, input crystal, input tick, output ready);
endinterface

`default_nettype wire

// >>> design/pmc_osc_ready.sv
// Oscillator stabilisation counter: ready after a fixed number of ticks.
// Assumes run drops whenever the oscillator is stopped.
`default_nettype none

module pmc_osc_ready #(
  parameter logic [10:0] RC_CYCLES = 11'h002
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Oscillator link
  pmc_osc_if.osc o
);

  typedef struct packed {
    logic [10:0] cnt;
    logic ready;
  } pmc_osc_st_t;

  pmc_osc_st_t r_ff;
  pmc_osc_st_t nxt_r;
  logic [10:0] target;

  assign target = o.crystal ? pmc_pkg::XTAL_CYCLES : RC_CYCLES;
  assign o.ready = r_ff.ready;

  always_comb
  begin
    nxt_r = r_ff;
    if (!o.run)
    begin
      nxt_r.cnt = 11'h000;
      nxt_r.ready = 1'b0;
    end
    else if (!r_ff.ready && o.tick)
    begin
      nxt_r.cnt = r_ff.cnt + 11'h001;
      nxt_r.ready = (r_ff.cnt + 11'h001) == target;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ready_count_a: assert property (
    o.run && !r_ff.ready && o.tick && r_ff.cnt == target - 11'h001
    |=> r_ff.ready)
    else $error("ready flag missed its count");
  ready_early_a: assert property (
    $rose(r_ff.ready) |-> $past(o.tick) && r_ff.cnt == target)
    else $error("ready flag rose early");

endmodule

`default_nettype wire

// >>> design/pmc_top.sv
// Power-mode controller: clock source choice, halt into sleep or idle,
// wake-up, power-down and time-out flags, with an AXI4-Lite register port.
// Assumes halt and clear-watchdog strobes are one-cycle pulses from the core.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`default_nettype none

// Contract
// - selector 000/001, fast bit low: sub clock
// - on sub clock stop fast osc and dividers
// - fast bit or selector 010..111 returns fast
// - switch to slow waits for slow-ready flag
// - halt, no idle, all off: deep sleep
// - deep sleep clears and stops watchdog
// - halt, no idle, watchdog/detector on: light sleep
// - light sleep clears watchdog, runs on sub
// - halt, idle, no keep: low idle
// - low idle watchdog runs only from sub
// - halt, idle, keep: full idle, clocks on
// - full idle clears watchdog, resumes counting
// - sleep and idle preserve all state
// - halt sets power-down, clears time-out
// - power-down clears at reset/clear-watchdog only
// - wake on port edge, interrupt, overflow
// - overflow sets time-out, resets PC/SP only
// - enabled falling port edge wakes, resume
// - disabled or stack full: resume, pending
// - enabled with free stack: service interrupt
// - request already set does not wake
// - fast-ready after 1024 crystal cycles
// - slow-ready after 1024 crystal cycles
module pmc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core events
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic [7:0] irq_req,
  input wire logic [7:0] irq_en,
  input wire logic stack_full,
  input wire logic wdt_overflow,
  // Port A pins
  input wire logic [7:0] port_a_pin,
  // Clock control
  output logic sysclk_run,
  output logic [1:0] sysclk_src,
  output logic [2:0] clk_div_sel,
  output logic subclk_run,
  output logic hi_osc_run,
  output logic fh_div_run,
  // Watchdog control
  output logic wdt_clear,
  output logic wdt_run,
  // Core control
  output logic cpu_hold,
  output logic resume_next,
  output logic irq_take,
  output logic pc_sp_reset,
  output logic chip_reset_req
);

  typedef struct packed {
    pmc_pkg::pmc_state_t state;
    pmc_pkg::pmc_clksrc_t src;
    logic high_low_clock_select;
    logic idle_on_halt_enable;
    logic [2:0] clock_divider_select;
    logic keep_sysclk_in_idle;
    logic [7:0] port_a_wake_enable;
    logic [5:0] cfg;
    logic power_down_flag;
    logic watchdog_timeout_flag;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pa_prev;
    logic [7:0] irq_arm;
    logic [11:0] sub_div;
    logic sub_tick;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic sysclk_run;
    logic subclk_run;
    logic hi_run;
    logic wdt_clear;
    logic wdt_run;
    logic cpu_hold;
    logic resume;
    logic irq_take;
    logic pc_sp_reset;
    logic chip_rst;
  } pmc_st_t;

  pmc_st_t r_ff;
  pmc_st_t nxt_r;
  logic hi_ready;
  logic lo_ready;
  logic sleeping;
  logic slow;
  logic [7:0] port_fall;
  logic [7:0] irq_wake;
  logic wdt_on;

  pmc_osc_if hi_if ();
  pmc_osc_if lo_if ();

  // ==========================================================================
  // Oscillator ready counters
  assign hi_if.run = r_ff.hi_run;
  assign hi_if.crystal = r_ff.cfg[pmc_pkg::CFG_HI_XTAL];
  assign hi_if.tick = 1'b1;
  assign lo_if.run = r_ff.subclk_run;
  assign lo_if.crystal = r_ff.cfg[pmc_pkg::CFG_LO_XTAL];
  assign lo_if.tick = r_ff.sub_tick;
  assign hi_ready = hi_if.ready;
  assign lo_ready = lo_if.ready;

  pmc_osc_ready #(.RC_CYCLES(pmc_pkg::HI_RC_CYCLES)) u_hi_ready (
    .aclk(aclk),
    .aresetn(aresetn),
    .o(hi_if.osc)
  );

  pmc_osc_ready #(.RC_CYCLES(pmc_pkg::LO_RC_CYCLES)) u_lo_ready (
    .aclk(aclk),
    .aresetn(aresetn),
    .o(lo_if.osc)
  );

  // ==========================================================================
  // Decodes shared by the next-state logic and the checks
  assign sleeping = r_ff.state != pmc_pkg::ST_RUN;
  assign slow = pmc_pkg::is_slow(r_ff.high_low_clock_select,
                                 r_ff.clock_divider_select);
  assign port_fall = r_ff.pa_prev & ~r_ff.pa_s2 & r_ff.port_a_wake_enable;
  assign irq_wake = irq_req & r_ff.irq_arm;
  assign wdt_on = r_ff.cfg[pmc_pkg::CFG_WDT_ON];

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [31:0] mode_w;
    logic [31:0] wr;
    logic run_like;
    logic [7:0] wa;
    logic [7:0] ra;
    mode_w = '0;
    wr = '0;
    run_like = 1'b0;
    wa = {awaddr[7:2], 2'b00};
    ra = {araddr[7:2], 2'b00};
    nxt_r = r_ff;
    nxt_r.wdt_clear = 1'b0;
    nxt_r.resume = 1'b0;
    nxt_r.irq_take = 1'b0;
    nxt_r.pc_sp_reset = 1'b0;
    nxt_r.chip_rst = 1'b0;

    // Sub clock cycle ticks; the divider rests while the sub clock is off
    nxt_r.sub_tick = 1'b0;
    if (!r_ff.subclk_run)
      nxt_r.sub_div = 12'h000;
    else if (r_ff.sub_div == pmc_pkg::SUB_DIV - 12'h001)
    begin
      nxt_r.sub_div = 12'h000;
      nxt_r.sub_tick = 1'b1;
    end
    else
      nxt_r.sub_div = r_ff.sub_div + 12'h001;

    // Pin synchroniser, then a third stage for the edge
    nxt_r.pa_s1 = port_a_pin;
    nxt_r.pa_s2 = r_ff.pa_s1;
    nxt_r.pa_prev = r_ff.pa_s2;

    // Bus write: both channels taken together, one beat in flight
    if (r_ff.awready)
    begin
      nxt_r.awready = 1'b0;
      nxt_r.wready = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = pmc_pkg::RESP_OKAY;
      mode_w = {23'h000000, r_ff.keep_sysclk_in_idle,
                r_ff.clock_divider_select, 3'b000,
                r_ff.idle_on_halt_enable, r_ff.high_low_clock_select};
      case (wa)
        pmc_pkg::OFF_MODE:
        begin
          wr = pmc_pkg::merge(mode_w, wdata, wstrb);
          nxt_r.high_low_clock_select = wr[pmc_pkg::MODE_HIGH_LOW_CLOCK_SELECT_BIT];
          nxt_r.idle_on_halt_enable = wr[pmc_pkg::MODE_IDLE_ON_HALT_ENABLE_BIT];
          nxt_r.clock_divider_select = wr[pmc_pkg::MODE_CKS_LSB +: 3];
          nxt_r.keep_sysclk_in_idle = wr[pmc_pkg::MODE_KEEP_BIT];
        end
        pmc_pkg::OFF_STAT: ;
        pmc_pkg::OFF_WAKE:
        begin
          wr = pmc_pkg::merge({24'h000000, r_ff.port_a_wake_enable},
                              wdata, wstrb);
          nxt_r.port_a_wake_enable = wr[7:0];
        end
        pmc_pkg::OFF_CFG:
        begin
          wr = pmc_pkg::merge({26'h0000000, r_ff.cfg}, wdata, wstrb);
          nxt_r.cfg = wr[5:0];
        end
        default: nxt_r.bresp = pmc_pkg::RESP_SLVERR;
      endcase
    end
    else if (awvalid && wvalid && !r_ff.bvalid)
    begin
      nxt_r.awready = 1'b1;
      nxt_r.wready = 1'b1;
    end
    if (r_ff.bvalid && bready)
      nxt_r.bvalid = 1'b0;

    // Bus read
    if (r_ff.arready)
    begin
      nxt_r.arready = 1'b0;
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = pmc_pkg::RESP_OKAY;
      nxt_r.rdata = '0;
      case (ra)
        pmc_pkg::OFF_MODE:
        begin
          nxt_r.rdata[pmc_pkg::MODE_HIGH_LOW_CLOCK_SELECT_BIT] = r_ff.high_low_clock_select;
          nxt_r.rdata[pmc_pkg::MODE_IDLE_ON_HALT_ENABLE_BIT] = r_ff.idle_on_halt_enable;
          nxt_r.rdata[pmc_pkg::MODE_CKS_LSB +: 3] =
            r_ff.clock_divider_select;
          nxt_r.rdata[pmc_pkg::MODE_KEEP_BIT] = r_ff.keep_sysclk_in_idle;
        end
        pmc_pkg::OFF_STAT:
        begin
          nxt_r.rdata[pmc_pkg::STAT_PDF_BIT] = r_ff.power_down_flag;
          nxt_r.rdata[pmc_pkg::STAT_TO_BIT] = r_ff.watchdog_timeout_flag;
          nxt_r.rdata[pmc_pkg::STAT_HTO_BIT] = hi_ready;
          nxt_r.rdata[pmc_pkg::STAT_LTO_BIT] = lo_ready;
          nxt_r.rdata[pmc_pkg::STAT_STATE_LSB +: 3] = r_ff.state;
        end
        pmc_pkg::OFF_WAKE: nxt_r.rdata[7:0] = r_ff.port_a_wake_enable;
        pmc_pkg::OFF_CFG: nxt_r.rdata[5:0] = r_ff.cfg;
        default: nxt_r.rresp = pmc_pkg::RESP_SLVERR;
      endcase
    end
    else if (arvalid && !r_ff.rvalid)
      nxt_r.arready = 1'b1;
    if (r_ff.rvalid && rready)
      nxt_r.rvalid = 1'b0;

    // Clear-watchdog drops power-down; a halt in the same cycle wins below
    if (clr_wdt_exec)
    begin
      nxt_r.power_down_flag = 1'b0;
      nxt_r.wdt_clear = 1'b1;
    end

    case (r_ff.state)
      pmc_pkg::ST_RUN:
      begin
        // Slow mode only once the sub oscillator is stable
        if (slow)
        begin
          if (lo_ready)
            nxt_r.src = pmc_pkg::SRC_SUB;
        end
        else if (r_ff.high_low_clock_select)
          nxt_r.src = pmc_pkg::SRC_HIGH;
        else
          nxt_r.src = pmc_pkg::SRC_DIV;
        if (halt_exec)
        begin
          nxt_r.power_down_flag = 1'b1;
          nxt_r.watchdog_timeout_flag = 1'b0;
          nxt_r.wdt_clear = 1'b1;
          nxt_r.irq_arm = ~irq_req;
          if (r_ff.idle_on_halt_enable)
            nxt_r.state = r_ff.keep_sysclk_in_idle ?
                          pmc_pkg::ST_FULL_IDLE :
                          pmc_pkg::ST_LOW_IDLE;
          else if (wdt_on || r_ff.cfg[pmc_pkg::CFG_VDET_ON] ||
                   r_ff.cfg[pmc_pkg::CFG_LCD_ON])
            nxt_r.state = pmc_pkg::ST_LIGHT;
          else
            nxt_r.state = pmc_pkg::ST_DEEP;
        end
        if (wdt_overflow)
        begin
          nxt_r.watchdog_timeout_flag = 1'b1;
          nxt_r.chip_rst = 1'b1;
        end
      end
      pmc_pkg::ST_DEEP,
      pmc_pkg::ST_LIGHT,
      pmc_pkg::ST_LOW_IDLE,
      pmc_pkg::ST_FULL_IDLE:
      begin
        // Nothing but a wake event changes here, so all state is kept
        if (wdt_overflow)
        begin
          nxt_r.watchdog_timeout_flag = 1'b1;
          nxt_r.pc_sp_reset = 1'b1;
          nxt_r.state = pmc_pkg::ST_RUN;
        end
        else if (|irq_wake)
        begin
          nxt_r.state = pmc_pkg::ST_RUN;
          if (|(irq_wake & irq_en) && !stack_full)
            nxt_r.irq_take = 1'b1;
          else
            nxt_r.resume = 1'b1;
        end
        else if (|port_fall)
        begin
          nxt_r.state = pmc_pkg::ST_RUN;
          nxt_r.resume = 1'b1;
        end
      end
      default: nxt_r.state = pmc_pkg::ST_RUN;
    endcase

    // Clock and watchdog enables follow the state being entered
    run_like = nxt_r.state == pmc_pkg::ST_RUN ||
               nxt_r.state == pmc_pkg::ST_FULL_IDLE;
    nxt_r.sysclk_run = run_like;
    nxt_r.subclk_run = nxt_r.state != pmc_pkg::ST_DEEP;
    nxt_r.hi_run = run_like && nxt_r.src != pmc_pkg::SRC_SUB;
    nxt_r.wdt_run = wdt_on && (run_like ||
                    (nxt_r.state != pmc_pkg::ST_DEEP &&
                     r_ff.cfg[pmc_pkg::CFG_WDT_SUB]));
    // Core waits for the fast oscillator; software still polls the flag
    nxt_r.cpu_hold = nxt_r.state != pmc_pkg::ST_RUN ||
                     (nxt_r.src != pmc_pkg::SRC_SUB && !hi_ready);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_ff <= '0;
      r_ff.high_low_clock_select <= pmc_pkg::MODE_RST[0];
      r_ff.idle_on_halt_enable <= pmc_pkg::MODE_RST[1];
      r_ff.port_a_wake_enable <= pmc_pkg::WAKE_RST;
      r_ff.cfg <= pmc_pkg::CFG_RST[5:0];
      r_ff.sysclk_run <= 1'b1;
      r_ff.subclk_run <= 1'b1;
      r_ff.hi_run <= 1'b1;
      r_ff.cpu_hold <= 1'b1;
    end
    else
      r_ff <= nxt_r;
  end

  // ==========================================================================
  // Outputs
  assign awready = r_ff.awready;
  assign wready = r_ff.wready;
  assign bresp = r_ff.bresp;
  assign bvalid = r_ff.bvalid;
  assign arready = r_ff.arready;
  assign rdata = r_ff.rdata;
  assign rresp = r_ff.rresp;
  assign rvalid = r_ff.rvalid;
  assign sysclk_run = r_ff.sysclk_run;
  assign sysclk_src = r_ff.src;
  assign clk_div_sel = r_ff.clock_divider_select;
  assign subclk_run = r_ff.subclk_run;
  assign hi_osc_run = r_ff.hi_run;
  assign fh_div_run = r_ff.hi_run;
  assign wdt_clear = r_ff.wdt_clear;
  assign wdt_run = r_ff.wdt_run;
  assign cpu_hold = r_ff.cpu_hold;
  assign resume_next = r_ff.resume;
  assign irq_take = r_ff.irq_take;
  assign pc_sp_reset = r_ff.pc_sp_reset;
  assign chip_reset_req = r_ff.chip_rst;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  slow_select_a: assert property (
    !sleeping && slow && lo_ready |=> r_ff.src == pmc_pkg::SRC_SUB)
    else $error("slow mode not selected");
  fast_stop_a: assert property (
    r_ff.src == pmc_pkg::SRC_SUB |-> !hi_osc_run && !fh_div_run)
    else $error("fast clock left running on sub clock");
  fast_return_a: assert property (
    !sleeping && !slow |=> r_ff.src != pmc_pkg::SRC_SUB &&
    hi_osc_run == sysclk_run)
    else $error("fast clock not restored");
  slow_wait_a: assert property (
    $rose(r_ff.src == pmc_pkg::SRC_SUB) |-> $past(lo_ready))
    else $error("slow switch before slow oscillator ready");
  deep_entry_a: assert property (
    !sleeping && halt_exec && !r_ff.idle_on_halt_enable &&
    r_ff.cfg[2:0] == 3'h0
    |=> r_ff.state == pmc_pkg::ST_DEEP && !sysclk_run && !subclk_run &&
        wdt_clear && !wdt_run)
    else $error("deep sleep entry wrong");
  light_entry_a: assert property (
    !sleeping && halt_exec && !r_ff.idle_on_halt_enable &&
    (wdt_on || r_ff.cfg[pmc_pkg::CFG_VDET_ON])
    |=> r_ff.state == pmc_pkg::ST_LIGHT && !sysclk_run && subclk_run &&
        wdt_clear && wdt_run == (wdt_on && r_ff.cfg[pmc_pkg::CFG_WDT_SUB]))
    else $error("light sleep entry wrong");
  low_idle_a: assert property (
    !sleeping && halt_exec && r_ff.idle_on_halt_enable &&
    !r_ff.keep_sysclk_in_idle
    |=> r_ff.state == pmc_pkg::ST_LOW_IDLE && !sysclk_run && subclk_run &&
        wdt_run == (wdt_on && r_ff.cfg[pmc_pkg::CFG_WDT_SUB]))
    else $error("low idle entry wrong");
  full_idle_a: assert property (
    !sleeping && halt_exec && r_ff.idle_on_halt_enable &&
    r_ff.keep_sysclk_in_idle
    |=> r_ff.state == pmc_pkg::ST_FULL_IDLE && sysclk_run && subclk_run &&
        wdt_clear && wdt_run == wdt_on)
    else $error("full idle entry wrong");
  sleep_hold_a: assert property (
    sleeping && !wdt_overflow && !(|port_fall) && !(|irq_wake)
    |=> $stable(r_ff.state) && cpu_hold)
    else $error("sleep left without wake event");
  pdf_set_a: assert property (
    !sleeping && halt_exec && !wdt_overflow
    |=> r_ff.power_down_flag && !r_ff.watchdog_timeout_flag)
    else $error("halt flags wrong");
  pdf_clear_a: assert property (
    clr_wdt_exec && !(halt_exec && !sleeping) |=> !r_ff.power_down_flag)
    else $error("power-down flag not cleared");
  wdt_wake_a: assert property (
    sleeping && wdt_overflow
    |=> r_ff.watchdog_timeout_flag && pc_sp_reset && !chip_reset_req &&
        r_ff.state == pmc_pkg::ST_RUN)
    else $error("watchdog wake wrong");
  port_wake_a: assert property (
    sleeping && |port_fall && !wdt_overflow && !(|irq_wake)
    |=> resume_next && !irq_take && r_ff.state == pmc_pkg::ST_RUN)
    else $error("port wake wrong");
  irq_wake_a: assert property (
    sleeping && |irq_wake && !wdt_overflow
    |=> irq_take == (|($past(irq_wake) & $past(irq_en)) &&
                     !$past(stack_full)) &&
        resume_next == !irq_take)
    else $error("interrupt wake wrong");

  deep_cycle_c: cover property (
    r_ff.state == pmc_pkg::ST_DEEP ##[1:20] r_ff.state == pmc_pkg::ST_RUN);
  light_cycle_c: cover property (
    r_ff.state == pmc_pkg::ST_LIGHT ##1 pc_sp_reset);
  idle_irq_c: cover property (
    r_ff.state == pmc_pkg::ST_FULL_IDLE ##1 irq_take);
  slow_mode_c: cover property ($rose(r_ff.src == pmc_pkg::SRC_SUB));

endmodule

`default_nettype wire

// >>> dv/pmc_core_model.sv
// Core model: halt strobes and held interrupt requests.
// Assumes the bench asks for events just after a rising edge.
`default_nettype none
module pmc_core_model (
  // Clock
  input wire logic aclk,
  // Bench requests
  input wire logic halt_req,
  input wire logic [7:0] irq_set,
  input wire logic sw_clr,
  // Controller side
  input wire logic irq_take,
  output logic halt_exec,
  output logic [7:0] irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {halt_exec, irq_req} = 9'h000;
  // Requests stay up until serviced or cleared by sw_clr, as a real core holds them
  always @(posedge aclk)
  begin
    halt_exec <= halt_req;
    if (irq_take === 1'h1 || sw_clr)
      irq_req <= 8'h00;
    else
      irq_req <= irq_req | irq_set;
  end
endmodule
`default_nettype wire

// >>> dv/power_mode_controller_bench.sv
// Bench for the power-mode controller: registers, halt modes, wake-up.
// Assumes pmc_core_model stands in for the core.
`default_nettype none
module power_mode_controller_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, halt_req = 1'h0;
  logic clr_wdt = 1'h0, stk = 1'h0, ovf = 1'h0, sw_clr = 1'h0, w;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pins = 8'hff;
  logic [7:0] irq_en = 8'h00, irq_set = 8'h00, irq_req;
  logic [31:0] wdata = 32'h0, rdata, m, c, d;
  logic [1:0] rresp, sysclk_src, rr, bresp, br;
  logic [2:0] e, cds;
  logic awready, wready, bvalid, arready, rvalid, sysclk_run, subclk_run;
  logic hi_osc_run, fh_div_run, wdt_clear, wdt_run, cpu_hold, resume_next;
  logic irq_take, pc_sp_reset, halt_exec, crr;
  logic [31:0] mtab [4] = '{32'h1, 32'h1, 32'h3, 32'h103};
  logic [31:0] ctab [4] = '{32'h0, 32'h9, 32'h1, 32'h1};
  int failures = 0, cmp_count = 0, st, k, b;

  pmc_top pmc_top_inst (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .halt_exec, .clr_wdt_exec(clr_wdt), .irq_req,
    .irq_en, .stack_full(stk), .wdt_overflow(ovf), .port_a_pin(pins),
    .sysclk_run, .sysclk_src, .clk_div_sel(cds), .subclk_run, .hi_osc_run,
    .fh_div_run, .wdt_clear, .wdt_run, .cpu_hold, .resume_next, .irq_take,
    .pc_sp_reset, .chip_reset_req(crr));
  pmc_core_model pmc_core_model_inst (.aclk, .halt_req, .irq_set, .sw_clr,
    .irq_take, .halt_exec, .irq_req);

  initial forever #4 aclk = ~aclk;

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    do @(posedge aclk); while (!(awready === 1'h1 && wready === 1'h1));
    {awvalid, wvalid} <= 2'h0;
    do @(posedge aclk); while (bvalid !== 1'h1);
    br = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    v = rdata;
    rr = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(98));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h00, d);
    chk(d, 32'h3);
    rd(8'h10, d);
    chk({rr, d}, 34'h2_0000_0000);
    repeat (1100) @(posedge aclk);
    chk(cpu_hold, 0);
    for (int j = 0; j < 8; j++)
    begin
      m = mtab[j % 4];
      c = ctab[j % 4];
      k = (j + 1 + j / 4) % 4;
      b = $urandom % 8;
      st = !m[1] ? (c[2:0] == 3'h0 ? 1 : 2) : (m[8] ? 4 : 3);
      wr(8'h0c, c);
      wr(8'h08, 32'h1 << b);
      wr(8'h00, m);
      irq_en <= 8'h1 << b;
      stk <= (k == 3);
      halt_req <= 1'h1;
      @(posedge aclk);
      halt_req <= 1'h0;
      w = 1'h0;
      repeat (4) @(posedge aclk) w |= wdt_clear;
      chk(w, 1);
      chk({sysclk_run, subclk_run, wdt_run, cpu_hold}, {st == 4, st != 1,
        c[0] && (st == 4 || (st != 1 && c[3])), 1'h1});
      rd(8'h04, d);
      chk(d & 32'h73, (st << 4) | 1);
      // Wake kinds: pin edge, taken irq, overflow, irq with stack full
      case (k)
        0: pins[b] <= 1'h0;
        2: ovf <= 1'h1;
        default: irq_set[b] <= 1'h1;
      endcase
      @(posedge aclk);
      {ovf, irq_set} <= 9'h0;
      e = 3'h0;
      repeat (40) @(posedge aclk) e |= {pc_sp_reset, irq_take, resume_next};
      chk(e, k == 2 ? 4 : (k == 1 ? 2 : 1));
      pins <= 8'hff;
      rd(8'h04, d);
      chk(d & 32'h73, {k == 2, 1'h1});
      {clr_wdt, sw_clr} <= 2'h3;
      @(posedge aclk);
      {clr_wdt, sw_clr} <= 2'h0;
      rd(8'h04, d);
      chk(d[0], 0);
    end
    // Overflow while running asks for a full reset and sets time-out
    ovf <= 1'h1;
    @(posedge aclk);
    ovf <= 1'h0;
    @(posedge aclk);
    chk(crr, 1);
    wr(8'h10, 32'h0);
    chk(br, 2);
    rd(8'h04, d);
    chk(d[1], 1);
    wr(8'h00, 32'h0);
    chk(br, 0);
    repeat (20000) if (sysclk_src !== 2'h2) @(posedge aclk);
    chk({sysclk_src, hi_osc_run, fh_div_run}, 4'h8);
    rd(8'h04, d);
    chk(d[3], 1);
    wr(8'h00, 32'h40);
    d = 32'h0;
    for (int i = 0; i < 50 && !d[2]; i++) rd(8'h04, d);
    chk({sysclk_src, hi_osc_run, d[2]}, 4'h7);
    chk(cds, 3'h2);
    stop_test();
  end

  initial
  begin
    repeat (45000) @(posedge aclk);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
